/* File: src/ead_pkg.sv */
// Shared constants, register map and carrier types for the external address detect port.
// Assumes a single 20 MHz system clock and a 32-bit Avalon-MM register bus.
package ead_pkg;

  // Register byte addresses.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PHYS_LO = 8'h04;
  localparam logic [7:0] REG_PHYS_HI = 8'h08;
  localparam logic [7:0] REG_LAF_LO = 8'h0c;
  localparam logic [7:0] REG_LAF_HI = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // Control register field positions.
  localparam int CTRL_START = 0;
  localparam int CTRL_RX_DIS = 1;
  localparam int CTRL_TX_DIS = 2;
  localparam int CTRL_UCAST_DIS = 3;
  localparam int CTRL_RUNT = 4;
  localparam int CTRL_PORT_SEL = 5;
  localparam int CTRL_GSP_SEL = 6;
  localparam int CTRL_PROMISC = 15;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Status register field positions.
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_ACCEPT = 1;
  localparam int STAT_REJECT = 2;
  localparam int STAT_OVF = 3;
  localparam int STAT_BYTES_LSB = 8;
  localparam int STAT_FRAMES_LSB = 16;

  // Frame geometry in bytes; LAST_BIT is the last bit index of a byte.
  localparam logic [6:0] WINDOW_BYTES = 7'h40;
  localparam logic [6:0] MIN_FRAME_BYTES = 7'h40;
  localparam logic [6:0] DEST_BYTES = 7'h06;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Reject pulse qualification time.
  localparam int REJ_PULSE_NS = 200;
  localparam int MCLK_PERIOD_NS = 50;
  localparam int REJ_CYCLES = (REJ_PULSE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [2:0] REJ_CNT = 3'(REJ_CYCLES);

  typedef struct packed {
    logic promisc;
    logic gsp_sel;
    logic port_sel;
    logic runt_accept;
    logic ucast_dis;
    logic tx_dis;
    logic rx_dis;
    logic start;
  } ead_cfg_s;

  typedef struct packed {
    logic last;
    logic keep;
    logic [7:0] data;
  } ead_word_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HUNT = 3'b010,
    ST_DATA = 3'b100
  } ead_state_e;

  function automatic logic [31:0] ead_be_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

/* File: src/ead_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is a slow level; bits are not kept coherent with each other.
`timescale 1ns/1ns
module ead_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule

/* File: src/ead_fifo.sv */
// Synchronous FIFO with a registered output stage and valid/ready on both sides.
// Assumes one clock; o_ready falls only when the memory is full, whatever the output stage holds.
`timescale 1ns/1ns
module ead_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;
  wire mem_empty = (wptr == rptr);
  wire mem_full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
  wire load = !mem_empty && (!o_valid || i_ready);
  wire push = i_valid && !mem_full;

  assign o_ready = !mem_full;

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= i_data;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wptr <= '0;
      rptr <= '0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (load) begin
        rptr <= rptr + 1'b1;
        o_data <= mem[rptr[AW-1:0]];
        o_valid <= 1'b1;
      end else if (i_ready) begin
        o_valid <= 1'b0;
      end
    end
  end
endmodule

/* File: src/ead_port.sv */
// External address detect port: serial receive tap, byte strobe, reject input and frame filter.
// Assumes the receive clock, data and carrier pins are asynchronous to i_mclk and far slower.
// Received bytes and a per-frame trailer word leave through a FIFO toward the DMA side.
//
// The implementer's own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
// How it works
// RULE1: Port runs only when select bit set.
// RULE2: Tap decoder or general serial port source.
// RULE3: Receive clock out toggles only during frames.
// RULE4: Strobe rises on the delimiter's two ones.
// RULE5: Strobe then marks every byte boundary.
// RULE6: External logic deserialises and drives reject low.
// RULE7: Internal address match always accepts frame.
// RULE8: Frames failing internal compare keep being received.
// RULE9: Reject ignored after 64 bytes past delimiter.
// RULE10: With runts, reject before message completes.
// RULE11: Reject low pulse lasts at least 200 ns.
// RULE12: Promiscuous mode accepts all, ignores reject.
// RULE13: Unicast off, filter zero: unrejected frames only.
// RULE14: Port runs with start set; no DMA when disabled.
// RULE15: Reject within 512 bits limits to matches.
// RULE16: Reject synchronised, latched per frame, cleared at delimiter.
module ead_port #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_dec_rx_clk,
  input wire logic i_dec_rx_data,
  input wire logic i_dec_rx_active,
  input wire logic i_gsp_rx_clk,
  input wire logic i_gsp_rx_data,
  input wire logic i_gsp_rx_active,
  input wire logic [5:0] i_mcast_hash,
  input wire logic i_ext_reject_n,
  output logic o_serial_rx_clock_out,
  output logic o_serial_rx_data_out,
  output logic o_frame_byte_strobe,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output ead_pkg::ead_word_s o_rx_word
);
  import ead_pkg::*;

  // Register file.
  logic [31:0] ctrl;
  logic [31:0] phys_lo;
  logic [15:0] phys_hi;
  logic [31:0] laf_lo;
  logic [31:0] laf_hi;
  logic ovf;
  logic [15:0] frame_cnt;
  logic last_accept;
  logic ack;

  // Link sampling.
  logic [6:0] pins_s;
  logic rclk_d;
  ead_state_e state;
  ead_state_e next_state;
  logic prev_bit;
  logic [2:0] bit_cnt;
  logic [6:0] byte_cnt;
  logic [7:0] shreg;
  logic match_ok;
  logic mcast;
  logic reject_latch;
  logic [2:0] low_cnt;
  logic end_pend;
  logic end_keep;

  wire ead_cfg_s cfg = '{promisc: ctrl[CTRL_PROMISC], gsp_sel: ctrl[CTRL_GSP_SEL],
                         port_sel: ctrl[CTRL_PORT_SEL], runt_accept: ctrl[CTRL_RUNT],
                         ucast_dis: ctrl[CTRL_UCAST_DIS], tx_dis: ctrl[CTRL_TX_DIS],
                         rx_dis: ctrl[CTRL_RX_DIS], start: ctrl[CTRL_START]};

  // Bus decode.
  wire req = i_avs_read || i_avs_write;
  wire sel_ctrl = (i_avs_address == REG_CTRL);
  wire sel_phys_lo = (i_avs_address == REG_PHYS_LO);
  wire sel_phys_hi = (i_avs_address == REG_PHYS_HI);
  wire sel_laf_lo = (i_avs_address == REG_LAF_LO);
  wire sel_laf_hi = (i_avs_address == REG_LAF_HI);
  wire sel_status = (i_avs_address == REG_STATUS);
  wire wr_take = i_avs_write && ack;
  wire rd_load = i_avs_read && !ack;
  wire [31:0] phys_hi_merged = ead_be_merge({16'h0000, phys_hi}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] status_word = {frame_cnt, 1'b0, byte_cnt, 4'h0, ovf, reject_latch, last_accept,
                             (state != ST_IDLE)};
  wire [31:0] rd_mux = sel_ctrl ? ctrl :
                       sel_phys_lo ? phys_lo :
                       sel_phys_hi ? {16'h0000, phys_hi} :
                       sel_laf_lo ? laf_lo :
                       sel_laf_hi ? laf_hi :
                       sel_status ? status_word : ZERO_WORD;

  // One wait state on every access keeps read data registered.
  assign o_avs_waitrequest = req && !ack;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ack <= 1'b0;
      o_avs_readdata <= ZERO_WORD;
    end else begin
      ack <= req && !ack;
      if (rd_load) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= CTRL_RESET;
      phys_lo <= ZERO_WORD;
      phys_hi <= 16'h0000;
      laf_lo <= ZERO_WORD;
      laf_hi <= ZERO_WORD;
    end else if (wr_take) begin
      if (sel_ctrl) begin
        ctrl <= ead_be_merge(ctrl, i_avs_writedata, i_avs_byteenable);
      end else if (sel_phys_lo) begin
        phys_lo <= ead_be_merge(phys_lo, i_avs_writedata, i_avs_byteenable);
      end else if (sel_phys_hi) begin
        phys_hi <= phys_hi_merged[15:0];
      end else if (sel_laf_lo) begin
        laf_lo <= ead_be_merge(laf_lo, i_avs_writedata, i_avs_byteenable);
      end else if (sel_laf_hi) begin
        laf_hi <= ead_be_merge(laf_hi, i_avs_writedata, i_avs_byteenable);
      end
    end
  end

  // All link pins pass two flops before anything looks at them.
  ead_sync #(
    .W(7)
  ) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d({i_gsp_rx_active, i_gsp_rx_data, i_gsp_rx_clk, i_ext_reject_n,
          i_dec_rx_active, i_dec_rx_data, i_dec_rx_clk}),
    .o_q(pins_s)
  );

  wire en = cfg.port_sel && cfg.start; // RULE1 RULE14
  wire rclk = cfg.gsp_sel ? pins_s[4] : pins_s[0]; // RULE2
  wire rdat = cfg.gsp_sel ? pins_s[5] : pins_s[1]; // RULE2
  wire ract = cfg.gsp_sel ? pins_s[6] : pins_s[2]; // RULE2
  wire rej_low = !pins_s[3];
  wire rise = rclk && !rclk_d && en;
  wire sfd_hit = (state == ST_HUNT) && rise && rdat && prev_bit; // RULE4
  wire byte_done = (state == ST_DATA) && rise && (bit_cnt == LAST_BIT);
  wire frame_end = (state == ST_DATA) && (next_state == ST_IDLE);
  wire [7:0] next_byte = {rdat, shreg[7:1]};
  wire in_window = (state == ST_DATA) && (byte_cnt < WINDOW_BYTES); // RULE9 RULE15
  wire deliver = !cfg.rx_dis; // RULE14

  // Internal filter; incoming frames are never cut short by a miss, so the reject window stays open.
  wire [47:0] phys48 = {phys_hi, phys_lo};
  wire [63:0] laf64 = {laf_hi, laf_lo};
  wire [7:0] phys_byte = phys48[byte_cnt[2:0]*8 +: 8];
  wire dest_done = (byte_cnt >= DEST_BYTES);
  wire phys_hit = dest_done && match_ok && !mcast && !cfg.ucast_dis; // RULE7 RULE13
  wire log_hit = dest_done && mcast && (laf64 != 64'h0) && laf64[i_mcast_hash]; // RULE7 RULE13
  wire long_enough = cfg.runt_accept || (byte_cnt >= MIN_FRAME_BYTES);
  wire accept = long_enough && (cfg.promisc || phys_hit || log_hit || !reject_latch); // RULE7 RULE12 RULE15

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (en && ract) begin
          next_state = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (!en || !ract) begin
          next_state = ST_IDLE;
        end else if (sfd_hit) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!en || !ract) begin
          next_state = ST_IDLE; // RULE8
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      rclk_d <= 1'b0;
      prev_bit <= 1'b0;
    end else begin
      state <= next_state;
      rclk_d <= rclk;
      prev_bit <= (state == ST_HUNT) ? (rise ? rdat : prev_bit) : 1'b0;
    end
  end

  // Bit and byte framing after the delimiter.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 7'h00;
      shreg <= 8'h00;
    end else if (sfd_hit) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 7'h00;
    end else if ((state == ST_DATA) && rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg <= next_byte;
      if (byte_done && (byte_cnt != 7'h7f)) begin
        byte_cnt <= byte_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      match_ok <= 1'b0;
      mcast <= 1'b0;
    end else if (sfd_hit) begin
      match_ok <= 1'b1;
      mcast <= 1'b0;
    end else if (byte_done && !dest_done) begin
      match_ok <= match_ok && (next_byte == phys_byte);
      if (byte_cnt == 7'h00) begin
        mcast <= next_byte[0];
      end
    end
  end

  // Pins out: strobe stands for one receive bit time at each boundary.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_frame_byte_strobe <= 1'b0;
      o_serial_rx_clock_out <= 1'b0;
      o_serial_rx_data_out <= 1'b0;
    end else begin
      if (sfd_hit || byte_done) begin
        o_frame_byte_strobe <= 1'b1; // RULE4 RULE5
      end else if (rise || !en || (state == ST_IDLE)) begin
        o_frame_byte_strobe <= 1'b0;
      end
      o_serial_rx_clock_out <= rclk && ract && en; // RULE3
      o_serial_rx_data_out <= rdat && en;
    end
  end

  // Reject must be seen low for the full pulse time inside the window.
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt <= 3'h0;
      reject_latch <= 1'b0;
    end else if (sfd_hit) begin
      low_cnt <= 3'h0;
      reject_latch <= 1'b0; // RULE16
    end else if (rej_low && in_window && !cfg.promisc) begin // RULE12
      if (low_cnt != REJ_CNT) begin
        low_cnt <= low_cnt + 3'h1; // RULE11
      end
      if (low_cnt == REJ_CNT - 3'h1) begin
        reject_latch <= 1'b1; // RULE16
      end
    end else begin
      low_cnt <= 3'h0;
    end
  end

  // Frame outcome and trailer word.
  wire push_byte = byte_done && deliver;
  wire push_end = end_pend && !push_byte;
  wire fifo_ready;
  wire ead_word_s push_word = push_byte ? ead_word_s'{last: 1'b0, keep: 1'b1, data: next_byte}
                                        : ead_word_s'{last: 1'b1, keep: end_keep, data: 8'h00};
  wire push_valid = push_byte || (push_end && deliver);
  wire ovf_set = push_valid && !fifo_ready;
  wire ovf_clr = wr_take && sel_status && i_avs_byteenable[0] && i_avs_writedata[STAT_OVF];

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      end_pend <= 1'b0;
      end_keep <= 1'b0;
      last_accept <= 1'b0;
      frame_cnt <= 16'h0000;
      ovf <= 1'b0;
    end else begin
      if (frame_end) begin
        end_pend <= 1'b1;
        end_keep <= accept;
        last_accept <= accept;
        if (accept) begin
          frame_cnt <= frame_cnt + 16'h0001;
        end
      end else if (push_end) begin
        end_pend <= 1'b0;
      end
      if (ovf_set) begin
        ovf <= 1'b1;
      end else if (ovf_clr) begin
        ovf <= 1'b0;
      end
    end
  end

  wire fifo_out_valid;
  ead_fifo #(
    .W($bits(ead_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_valid(push_valid),
    .o_ready(fifo_ready),
    .i_data(push_word),
    .o_valid(fifo_out_valid),
    .i_ready(i_rx_ready && deliver),
    .o_data(o_rx_word)
  );
  assign o_rx_valid = fifo_out_valid && deliver; // RULE14

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_two_ones;
    (state == ST_HUNT) && rise && rdat && prev_bit;
  endsequence
  sequence s_low_run;
    (rej_low && in_window && !cfg.promisc && !sfd_hit) [*4];
  endsequence

  AST_PORT_OFF: assert property (!en |=> state == ST_IDLE) // RULE1
    else $error("Port left idle while not selected.");
  AST_CLK_QUIET: assert property (!en |=> !o_serial_rx_clock_out) // RULE3
    else $error("Receive clock out moved while port disabled.");
  AST_SFD_STROBE: assert property (s_two_ones |=> o_frame_byte_strobe && (state == ST_DATA)) // RULE4
    else $error("Strobe did not rise at delimiter.");
  AST_BYTE_STROBE: assert property (byte_done && en && ract |=> o_frame_byte_strobe) // RULE5
    else $error("Strobe missing at byte boundary.");
  AST_MATCH_WINS: assert property (frame_end && long_enough && (phys_hit || log_hit) |=> end_keep) // RULE7
    else $error("Internal match frame was dropped.");
  AST_WINDOW_SHUT: assert property ((state == ST_DATA) && (byte_cnt >= WINDOW_BYTES) && !reject_latch
                                    && !sfd_hit |=> !reject_latch) // RULE9
    else $error("Reject taken after window closed.");
  AST_PROMISC_ALL: assert property (frame_end && cfg.promisc && long_enough |=> end_keep) // RULE12
    else $error("Promiscuous frame was dropped.");
  AST_FILTER_ZERO: assert property (frame_end && cfg.ucast_dis && (laf64 == 64'h0) && reject_latch
                                    && !cfg.promisc |=> !end_keep) // RULE13
    else $error("Rejected frame kept with filters off.");
  AST_REJ_LATCH: assert property (s_low_run |=> reject_latch) // RULE16
    else $error("Qualified reject pulse not latched.");
  AST_NO_DMA: assert property (cfg.rx_dis |-> !o_rx_valid) // RULE14
    else $error("Data offered while receive disabled.");
  AST_BUS_WAIT: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("Bus answer took more than one wait state.");

endmodule

/* File: verif/ead_cam_model.sv */
// Behavioural model of the external address comparison logic at the port's far side.
// Assumes the port's receive clock, data and strobe outputs, sampled on i_mclk.
`timescale 1ns/1ns
module ead_cam_model (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_clk,
  input wire logic i_data,
  input wire logic i_strobe,
  input wire logic [6:0] i_rej_at,
  output logic o_ext_reject_n,
  output logic [7:0] o_first_byte
);
  logic clk_q, stb_q, armed, done;
  logic [7:0] sr;
  logic [2:0] nbit, low_cnt;
  logic [6:0] nbyte;
  logic [3:0] idle;
  wire rise = i_clk & ~clk_q;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      {clk_q, stb_q, armed, done, sr, nbit, low_cnt, nbyte, idle} <= '0;
      o_ext_reject_n <= 1'b1;
      o_first_byte <= 8'h00;
    end else begin
      clk_q <= i_clk;
      stb_q <= i_strobe;
      idle <= rise ? 4'h0 : idle + 4'(idle != 4'hf);
      // A quiet clock for two bit times ends the frame, so the next strobe starts a new one.
      if (idle == 4'hf) begin
        {armed, done, nbyte} <= '0;
      end else if (i_strobe & ~stb_q & ~armed) begin
        armed <= 1'b1;
        nbit <= 3'h0;
      end else if (rise & armed) begin
        sr <= {i_data, sr[7:1]};
        nbit <= nbit + 3'h1;
        if (nbit == 3'h7) begin
          nbyte <= nbyte + 7'h1;
        end
        if (nbit == 3'h7 && nbyte == 7'h00) begin
          o_first_byte <= {i_data, sr[7:1]};
        end
      end
      // Six cycles low is 300 ns, safely above the shortest pulse that counts.
      if (!done && i_rej_at != 7'h00 && nbyte == i_rej_at) begin
        done <= 1'b1;
        low_cnt <= 3'h6;
      end else if (low_cnt != 3'h0) begin
        low_cnt <= low_cnt - 3'h1;
      end
      o_ext_reject_n <= (low_cnt == 3'h0);
    end
  end
endmodule

/* File: verif/external_address_detect_port_test.sv */
// Self-checking bench for the external address detect port: register bus, serial link, FIFO drain.
// Assumes the port design files and the far-side comparison model are compiled first.
`timescale 1ns/1ns
module external_address_detect_port_test;
  import ead_pkg::*;
  logic i_mclk, i_rst, avs_r, avs_w, lk_clk, lk_dat, lk_act, use_gsp, rx_rdy, stb_q, sck_q, keep_seen;
  logic avs_wait, sck, sdat, stb, rx_valid, rej_n;
  logic [7:0] avs_a, first_byte;
  logic [31:0] avs_wd, avs_rdata, rd;
  logic [3:0] avs_be;
  logic [6:0] rej_at;
  logic [7:0] got [0:2047];
  ead_word_s rx_word;
  int bad_count, total_checks, cyc, n_stb, n_sck, n_wd, n_trl, tnum;

  ead_port #(.FIFO_DEPTH(32)) dut_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_avs_address(avs_a), .i_avs_read(avs_r), .i_avs_write(avs_w),
    .i_avs_writedata(avs_wd), .i_avs_byteenable(avs_be), .o_avs_readdata(avs_rdata),
    .o_avs_waitrequest(avs_wait), .i_dec_rx_clk(lk_clk & ~use_gsp), .i_dec_rx_data(lk_dat ^ use_gsp),
    .i_dec_rx_active(lk_act & ~use_gsp), .i_gsp_rx_clk(lk_clk & use_gsp), .i_gsp_rx_data(lk_dat ^ ~use_gsp),
    .i_gsp_rx_active(lk_act & use_gsp), .i_mcast_hash(6'h05), .i_ext_reject_n(rej_n),
    .o_serial_rx_clock_out(sck), .o_serial_rx_data_out(sdat), .o_frame_byte_strobe(stb),
    .o_rx_valid(rx_valid), .i_rx_ready(rx_rdy), .o_rx_word(rx_word)
  );
  ead_cam_model cam_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_clk(sck), .i_data(sdat), .i_strobe(stb), .i_rej_at(rej_at),
    .o_ext_reject_n(rej_n), .o_first_byte(first_byte)
  );

  always #25 i_mclk = ~i_mclk;

  always @(posedge i_mclk) begin
    stb_q <= stb;
    sck_q <= sck;
    cyc++;
    if (stb === 1'b1 && stb_q === 1'b0) n_stb++;
    if (sck === 1'b1 && sck_q === 1'b0) n_sck++;
    if (rx_valid === 1'b1 && rx_rdy === 1'b1) begin
      if (rx_word.last === 1'b1) begin
        n_trl++;
        keep_seen = rx_word.keep;
      end else begin
        got[n_wd % 2048] = rx_word.data;
        n_wd++;
      end
    end
    if (cyc == 80000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One bus cycle; the request is held until waitrequest is sampled low.
  task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int k;
    @(posedge i_mclk);
    avs_a <= a;
    avs_wd <= d;
    avs_be <= be;
    avs_w <= wr;
    avs_r <= ~wr;
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (avs_wait !== 1'b0 && k < 50);
    rd = avs_rdata;
    avs_w <= 1'b0;
    avs_r <= 1'b0;
    if (k >= 50) bad_count++;
  endtask

  // One 400 ns link bit; data changes while the link clock is low.
  task automatic bit_out(input logic b);
    @(posedge i_mclk);
    lk_dat <= b;
    lk_clk <= 1'b0;
    repeat (4) @(posedge i_mclk);
    lk_clk <= 1'b1;
    repeat (3) @(posedge i_mclk);
  endtask

  task automatic send(input int n, input logic [7:0] base);
    logic [7:0] b;
    @(posedge i_mclk);
    lk_act <= 1'b1;
    repeat (8) @(posedge i_mclk);
    for (int i = 0; i < 8; i++) begin
      bit_out(1'(i == 7 || i % 2 == 0));
    end
    for (int k = 0; k < n; k++) begin
      b = base + 8'(k);
      for (int j = 0; j < 8; j++) begin
        bit_out(b[j]);
      end
    end
    // The link clock stands still after the frame and the data line stops showing the last bit.
    @(posedge i_mclk);
    lk_clk <= 1'b0;
    lk_dat <= ~lk_dat;
    repeat (8) @(posedge i_mclk);
    lk_act <= 1'b0;
  endtask

  task automatic run(input logic [15:0] ctrl, input logic [31:0] laf, input logic [7:0] base, input int n,
                     input logic [6:0] rej, input logic gsp, input logic rdy, input logic en, input logic words,
                     input logic keep);
    int s0, c0, w0, t0;
    avs(1'b1, REG_CTRL, {16'h0000, ctrl}, 4'hf);
    avs(1'b1, REG_LAF_LO, laf, 4'hf);
    @(posedge i_mclk);
    rej_at <= rej;
    use_gsp <= gsp;
    rx_rdy <= rdy;
    s0 = n_stb;
    c0 = n_sck;
    w0 = n_wd;
    t0 = n_trl;
    send(n, base);
    for (int k = 0; k < 80 && n_trl == t0; k++) @(posedge i_mclk);
    repeat (2) @(posedge i_mclk);
    check(32'(n_stb - s0), en ? 32'(n + 1) : ZERO_WORD);
    check(32'(n_sck - c0), en ? 32'(8 * n + 8) : ZERO_WORD);
    check(32'(n_trl - t0), 32'(words));
    if (en) check(32'(first_byte), 32'(base));
    if (words) begin
      check(32'(n_wd - w0), 32'(n));
      check(32'(keep_seen), 32'(keep));
      for (int k = 0; k < n; k++) check(32'(got[(w0 + k) % 2048]), 32'(8'(base + 8'(k))));
      avs(1'b0, REG_STATUS, ZERO_WORD, 4'hf);
      check(32'(rd[STAT_ACCEPT]), 32'(keep));
      check(32'(rd[14:8]), 32'(n));
      check(32'(rd[STAT_REJECT]), 32'(rej != 0 && rej < 64 && !ctrl[15]));
    end
    $display("test %0d done", tnum);
    tnum++;
  endtask

  initial begin
    {i_mclk, i_rst, avs_r, avs_w, lk_clk, lk_dat, lk_act, use_gsp, rx_rdy, stb_q, sck_q, keep_seen} = 12'h400;
    {avs_a, avs_wd, avs_be, rej_at} = '0;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    avs(1'b0, REG_CTRL, ZERO_WORD, 4'hf);
    check(rd, CTRL_RESET);
    avs(1'b0, REG_STATUS, ZERO_WORD, 4'hf);
    check(rd, ZERO_WORD);
    avs(1'b1, REG_PHYS_LO, 32'h232221ff, 4'hf);
    avs(1'b1, REG_PHYS_LO, 32'h00000020, 4'h1);
    avs(1'b0, REG_PHYS_LO, ZERO_WORD, 4'hf);
    check(rd, 32'h23222120);
    avs(1'b1, REG_PHYS_HI, 32'hffff2524, 4'hf);
    avs(1'b0, REG_PHYS_HI, ZERO_WORD, 4'hf);
    check(rd, 32'h00002524);
    avs(1'b1, 8'h20, 32'h5a5a5a5a, 4'hf);
    avs(1'b0, 8'h20, ZERO_WORD, 4'hf);
    check(rd, ZERO_WORD);
    run(16'h0001, ZERO_WORD, 8'h20, 8, 7'h00, 0, 1, 0, 0, 0);
    run(16'h0021, ZERO_WORD, 8'h20, 64, 7'h02, 0, 1, 1, 1, 1);
    run(16'h0021, ZERO_WORD, 8'h30, 64, 7'h02, 0, 1, 1, 1, 0);
    run(16'h0021, ZERO_WORD, 8'h30, 64, 7'h00, 0, 1, 1, 1, 1);
    run(16'h0021, ZERO_WORD, 8'h30, 70, 7'h3f, 0, 1, 1, 1, 0);
    run(16'h0021, ZERO_WORD, 8'h30, 70, 7'h41, 0, 1, 1, 1, 1);
    run(16'h8021, ZERO_WORD, 8'h30, 64, 7'h02, 0, 1, 1, 1, 1);
    run(16'h0021, 32'h00000020, 8'h31, 64, 7'h02, 0, 1, 1, 1, 1);
    run(16'h0029, ZERO_WORD, 8'h20, 64, 7'h02, 0, 1, 1, 1, 0);
    run(16'h0031, ZERO_WORD, 8'h30, 20, 7'h00, 0, 1, 1, 1, 1);
    run(16'h0031, ZERO_WORD, 8'h30, 20, 7'h08, 0, 1, 1, 1, 0);
    run(16'h0021, ZERO_WORD, 8'h30, 20, 7'h00, 0, 1, 1, 1, 0);
    run(16'h0061, ZERO_WORD, 8'h50, 8, 7'h00, 1, 1, 1, 1, 0);
    run(16'h0027, ZERO_WORD, 8'h30, 8, 7'h00, 0, 1, 1, 0, 0);
    run(16'h0021, ZERO_WORD, 8'h30, 64, 7'h00, 0, 0, 1, 0, 0);
    avs(1'b0, REG_STATUS, ZERO_WORD, 4'hf);
    check(32'(rd[STAT_OVF]), 32'h1);
    check(32'(rd[31:16]), 32'h7);
    @(posedge i_mclk);
    rx_rdy <= 1'b1;
    for (int k = 0; k < 200 && rx_valid !== 1'b0; k++) @(posedge i_mclk);
    check(32'(rx_valid), ZERO_WORD);
    avs(1'b1, REG_STATUS, 32'h00000008, 4'hf);
    avs(1'b0, REG_STATUS, ZERO_WORD, 4'hf);
    check(32'(rd[STAT_OVF]), ZERO_WORD);
    end_of_test();
  end
endmodule
